// ### src/pms_sequencer.sv
// measurement scheduler and position filter with a buffered result stream
`timescale 1ns/1ps
module pms_sequencer #(
  parameter int POS_W = pms_pkg::POS_W,
  parameter int FIFO_DEPTH = pms_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic continuous_run,
  input wire logic go,
  input wire logic pipeline_request,
  input wire logic incremental_request,
  input wire logic [3:0] absolute_interval_select,
  input wire logic [3:0] filter_coefficient_select,
  input wire logic [15:0] sample_interval_setting,
  input wire logic sync_trigger_input_n,
  output logic meas_start,
  output logic meas_coarse,
  input wire logic meas_done,
  input wire logic meas_valid,
  input wire logic [POS_W-1:0] meas_position,
  output logic pipeline_active_flag,
  output logic res_valid,
  input wire logic res_ready,
  output logic [POS_W-1:0] res_position,
  output logic res_incremental_flag,
  output logic res_position_valid
);
  localparam int FW = POS_W + pms_pkg::FRAC_W; // filter state width
  localparam int RW = POS_W + 2; // buffered word width

  typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_BUSY, ST_POST} pms_state_type;

  pms_state_type st_q; // sequencer state
  logic sync_s1_q; // first sync stage
  logic sync_s2_q; // second sync stage
  logic sync_s3_q; // third sync stage
  logic sync_lvl_q; // agreed level of the sync input
  logic sync_fall; // agreed falling edge
  logic run_continuous_run; // internally timed sampling
  logic run_pipe; // externally triggered pipeline
  logic running; // any sampling mode active
  logic start_run; // first cycle of a run
  logic [3:0] abs_sel_q; // captured interval select
  logic [31:0] interval_q; // sample interval in cycles
  logic [31:0] timer_q; // countdown to the next internal sample
  logic tick; // internal sample moment
  logic trig; // sample request from the active source
  logic space; // buffer can take one more result
  logic take; // trigger accepted
  logic prev_inc_q; // request bit seen at the previous sample
  logic [15:0] inc_count_q; // incremental measurements since last absolute
  logic [15:0] run_len; // incremental run length, wide enough for select fifteen
  logic host_abs; // host asked for one absolute
  logic auto_abs; // counted run has ended
  logic abs_needed_q; // no valid absolute yet
  logic coarse_now; // decision for the sample being taken
  logic meas_start_q; // start pulse register
  logic cur_coarse_q; // kind of the measurement in flight
  logic [FW-1:0] filt_q; // filter state with fraction
  logic filt_valid_q; // filter state holds real data
  logic [16:0] coef; // current k
  logic signed [POS_W-1:0] diff_s; // raw minus previous filtered
  logic signed [POS_W+17:0] prod; // scaled correction
  logic [FW-1:0] filt_d; // next filtered value
  logic [POS_W-1:0] res_pos_q; // result position register
  logic res_inc_q; // result kind register
  logic res_ok_q; // result validity register
  logic fifo_in_ready; // buffer fill-side ready
  logic [RW-1:0] fifo_out; // buffered word

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  assign run_continuous_run = continuous_run & go; // see RL11 see RL12
  assign run_pipe = pipeline_request & go & ~continuous_run; // see RL24
  assign running = run_continuous_run | run_pipe;
  assign start_run = (st_q == ST_IDLE) & running;

  // pipeline flag follows the enabled pipeline modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipeline_active_flag <= 1'b0;
    end else begin
      pipeline_active_flag <= pipeline_request & go; // see RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync input: three stages, a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
      sync_s3_q <= 1'b1;
      sync_lvl_q <= 1'b1;
    end else begin
      sync_s1_q <= sync_trigger_input_n;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      if (sync_s2_q == sync_s3_q) begin
        sync_lvl_q <= sync_s3_q;
      end
    end
  end
  assign sync_fall = (sync_s2_q == sync_s3_q) & ~sync_s3_q & sync_lvl_q; // see RL24

  ////////////////////////////////////////////////////////////////////////
  // configuration captured at the start of a run, so it stays steady
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abs_sel_q <= pms_pkg::ABS_SEL_RESET; // see RL9
      interval_q <= 32'h00000001;
    end else if (start_run) begin
      abs_sel_q <= absolute_interval_select; // see RL7
      if (sample_interval_setting == 16'h0000) begin
        interval_q <= 32'h00000001;
      end else begin
        interval_q <= 32'(sample_interval_setting) * 32'(pms_pkg::CYC_PER_TICK); // see RL14
      end
    end
  end

  // internal sample timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 32'h00000000;
    end else if (!run_continuous_run || start_run) begin
      timer_q <= 32'h00000000;
    end else if (timer_q == 32'h00000000) begin
      timer_q <= interval_q - 32'h00000001; // see RL11
    end else begin
      timer_q <= timer_q - 32'h00000001;
    end
  end
  assign tick = run_continuous_run & ~start_run & (timer_q == 32'h00000000);

  // trigger source: internal timer in continuous mode, sync edge otherwise
  assign trig = run_continuous_run ? tick : (run_pipe & sync_fall); // see RL13 see RL24
  assign space = fifo_in_ready;
  assign take = (st_q == ST_READY) & running & trig & space;

  ////////////////////////////////////////////////////////////////////////
  // absolute versus incremental decision
  assign run_len = 16'h0001 << abs_sel_q; // see RL9 see RL10
  assign host_abs = ~prev_inc_q & incremental_request; // see RL1 see RL4
  assign auto_abs = ~incremental_request & (inc_count_q >= run_len); // see RL2
  assign coarse_now = abs_needed_q | host_abs | auto_abs; // see RL23

  // request bit history and incremental counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_inc_q <= 1'b1;
      inc_count_q <= 16'h0000;
    end else if (start_run) begin
      prev_inc_q <= 1'b1;
      inc_count_q <= 16'h0000;
    end else if (take) begin
      prev_inc_q <= incremental_request;
      if (coarse_now) begin
        inc_count_q <= 16'h0000; // see RL26
      end else if (inc_count_q != 16'hFFFF) begin
        inc_count_q <= inc_count_q + 16'h0001;
      end
    end
  end

  // absolute needed until a valid absolute result comes back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abs_needed_q <= 1'b1;
    end else if (start_run) begin
      abs_needed_q <= 1'b1;
    end else if ((st_q == ST_BUSY) && meas_done) begin
      if (!meas_valid) begin
        abs_needed_q <= 1'b1; // see RL23
      end else if (cur_coarse_q) begin
        abs_needed_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (running) begin
            st_q <= ST_READY;
          end
        end
        ST_READY: begin
          if (!running) begin
            st_q <= ST_IDLE; // see RL12
          end else if (take) begin
            st_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (!running) begin
            st_q <= ST_IDLE;
          end else if (meas_done) begin
            st_q <= ST_POST;
          end
        end
        default: begin
          // result goes to the buffer this cycle; a stop still wins
          if (!running) begin
            st_q <= ST_IDLE; // see RL12
          end else begin
            st_q <= ST_READY;
          end
        end
      endcase
    end
  end

  // start pulse and kind of measurement toward the front end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_start_q <= 1'b0;
      cur_coarse_q <= 1'b1;
    end else begin
      meas_start_q <= take;
      if (take) begin
        cur_coarse_q <= coarse_now;
      end
    end
  end
  assign meas_start = meas_start_q;
  assign meas_coarse = cur_coarse_q;

  ////////////////////////////////////////////////////////////////////////
  // position filter: previous plus k times the difference
  assign coef = pms_pkg::pms_coef(filter_coefficient_select); // see RL21
  assign diff_s = $signed(meas_position - filt_q[FW-1 -: POS_W]);
  assign prod = diff_s * $signed({1'b0, coef});
  assign filt_d = filt_q + FW'(prod[FW-1:0]); // see RL20

  // filter state and result registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= '0;
      filt_valid_q <= 1'b0;
      res_pos_q <= '0;
      res_inc_q <= 1'b0;
      res_ok_q <= 1'b0;
    end else if (start_run) begin
      filt_valid_q <= 1'b0; // see RL25
    end else if ((st_q == ST_BUSY) && meas_done && running) begin
      res_inc_q <= ~cur_coarse_q; // see RL8
      res_ok_q <= meas_valid;
      if (!meas_valid) begin
        filt_valid_q <= 1'b0; // see RL25
        res_pos_q <= meas_position;
      end else if (!filt_valid_q || (filter_coefficient_select == 4'h0)) begin
        filt_q <= {meas_position, pms_pkg::FRAC_W'(0)}; // see RL19 see RL25
        filt_valid_q <= 1'b1;
        res_pos_q <= meas_position; // see RL5 see RL22
      end else begin
        filt_q <= filt_d;
        res_pos_q <= filt_d[FW-1 -: POS_W]; // see RL22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result buffer; readable any time, full buffer holds off new samples
  pms_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(st_q == ST_POST),
    .in_ready(fifo_in_ready),
    .in_data({res_ok_q, res_inc_q, res_pos_q}),
    .out_valid(res_valid),
    .out_ready(res_ready), // see RL15
    .out_data(fifo_out)
  );
  assign res_position = fifo_out[POS_W-1:0];
  assign res_incremental_flag = fifo_out[POS_W];
  assign res_position_valid = fifo_out[POS_W+1];

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_HOST_ABS: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL4
    take && host_abs |=> meas_start && meas_coarse)
    else $error("host absolute request did not start a coarse measurement");
  AST_AUTO_ABS: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL2
    take && !incremental_request && inc_count_q >= run_len |=> meas_start && meas_coarse)
    else $error("counted run end did not start a coarse measurement");
  AST_ALT_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL10
    take && abs_sel_q == 4'h0 && !incremental_request && !coarse_now
    |=> inc_count_q == 16'h0001)
    else $error("select zero run did not reach one incremental");
  AST_CNT_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL26
    take && coarse_now |=> inc_count_q == 16'h0000)
    else $error("incremental count not restarted after absolute");
  AST_INVALID_ABS: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL23
    st_q == ST_BUSY && meas_done && !meas_valid && running |=> abs_needed_q)
    else $error("invalid result did not force absolute mode");
  AST_ABS_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL23
    take && abs_needed_q |=> meas_start && meas_coarse)
    else $error("sample taken while absolute needed was not coarse");
  AST_FLAG_KIND: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL8
    st_q == ST_BUSY && meas_done && running |=> res_inc_q == !$past(cur_coarse_q))
    else $error("result flag does not match measurement kind");
  AST_RAW_PASS: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL19
    st_q == ST_BUSY && meas_done && running && filter_coefficient_select == 4'h0
    |=> res_pos_q == $past(meas_position))
    else $error("unfiltered result differs from latest measurement");
  AST_FIRST_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL25
    st_q == ST_BUSY && meas_done && running && meas_valid && !filt_valid_q
    |=> res_pos_q == $past(meas_position) && filt_valid_q)
    else $error("filter not loaded from raw position");
  AST_TIMED_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL13
    st_q == ST_READY && tick && space |=> meas_start)
    else $error("internal timer did not start a sample");
  AST_SYNC_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL24
    st_q == ST_READY && run_pipe && sync_fall && space |=> meas_start)
    else $error("sync edge did not start a pipeline sample");
  AST_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RL12
    !go |=> st_q == ST_IDLE)
    else $error("sampling did not stop with go cleared");
  COV_HOST_ABS: cover property (@(posedge sys_clk) disable iff (!rst_n) take && host_abs);
  COV_AUTO_ABS: cover property (@(posedge sys_clk) disable iff (!rst_n) take && auto_abs);
  COV_FILTERED: cover property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_BUSY && meas_done && filt_valid_q && filter_coefficient_select != 4'h0);
  COV_FULL: cover property (@(posedge sys_clk) disable iff (!rst_n) running && !space);
endmodule : pms_sequencer

// ### src/pms_pkg.sv
// constants, coefficient function and rule summary of the position measure sequencer
// Rules from the document, for the block and its host
// RL1: host clears request once for coarse
// RL2: held-zero request runs counted incremental measurements
// RL3: host clears then restores request bit
// RL4: coarse follows restore, flag reads zero
// RL5: absolute result repeats or corrects position
// RL6: other pipeline transactions may be read-only
// RL7: host sets interval select before starting
// RL8: flag one incremental, zero absolute
// RL9: interval select resets to twelve, 4096
// RL10: select zero alternates absolute and incremental
// RL11: continuous mode times samples internally
// RL12: continuous and go start, both clear stop
// RL13: continuous pipelined runs from internal timer
// RL14: host stops before changing sample interval
// RL15: results readable any time during continuous
// RL16: host treats low amplitude as invalid
// RL17: host keeps request zero when continuous
// RL18: host lengthens gap or uses burst
// RL19: unfiltered output is latest measurement
// RL20: filter adds k times difference
// RL21: select steps k by root half
// RL22: same format, 16 bits per period
// RL23: invalid result forces absolute until valid
// RL24: pipeline request plus sync edge triggers
// RL25: filter loads raw after start or invalid
// RL26: incremental counter restarts after every absolute
package pms_pkg;
  localparam int POS_W = 24; // 16 bits per sine period plus period count
  localparam int PERIOD_BITS = 16; // position bits inside one period
  localparam int FRAC_W = 16; // fraction bits of filter state and coefficient
  localparam logic [3:0] ABS_SEL_RESET = 4'hC; // reset interval select
  localparam int SEL_W = 4; // width of both select fields
  localparam int TICK_NS = 100; // unit of the sample interval setting
  localparam int CLK_NS = 10; // sys_clk period
  localparam int CYC_PER_TICK = (TICK_NS + CLK_NS - 1) / CLK_NS; // cycles per unit
  localparam int FIFO_DEPTH = 4; // result buffer depth
  localparam logic [16:0] K_ONE = 17'h10000; // k of one
  localparam logic [16:0] K_ROOT_HALF = 17'h0B505; // k of 0.7071

  // coefficient k in 1.16 fixed point: halves every two steps
  function automatic logic [16:0] pms_coef(input logic [3:0] sel);
    logic [16:0] base;
    base = sel[0] ? K_ROOT_HALF : K_ONE;
    pms_coef = base >> sel[3:1];
  endfunction : pms_coef
endpackage : pms_pkg

// ### src/pms_fifo.sv
// small result buffer with valid and ready on both sides
`timescale 1ns/1ps
module pms_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW-1:0] wr_ptr_q; // next write slot
  logic [AW-1:0] rd_ptr_q; // next read slot
  logic [AW:0] count_q; // words held
  logic do_wr; // accepted write
  logic do_rd; // accepted read

  assign in_ready = (count_q != (AW+1)'(DEPTH)); // full once DEPTH words are held
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////
  // storage write
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (do_wr && !do_rd) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end
endmodule : pms_fifo

// ### verif/pms_frontend_model.sv
// behavioural model of the measurement front end facing the sequencer
`timescale 1ns/1ps
module pms_frontend_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic meas_start,
  input wire logic [7:0] lat,
  input wire logic [pms_pkg::POS_W-1:0] pos_in,
  input wire logic valid_in,
  output logic meas_done,
  output logic meas_valid,
  output logic [pms_pkg::POS_W-1:0] meas_position
);
  logic [7:0] cnt_q; // cycles left before the answer
  logic busy_q; // measurement in flight
  logic [pms_pkg::POS_W-1:0] pos_q; // result held for the answer
  logic val_q; // validity held for the answer
  ////////////////////////////////////////////////////////////////
  // answer each start lat plus one cycles after it is seen; scramble lines between answers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      pos_q <= '0;
      val_q <= 1'b0;
      meas_done <= 1'b0;
      meas_valid <= 1'b0;
      meas_position <= '0;
    end else begin
      meas_done <= 1'b0;
      meas_valid <= ~meas_valid;
      meas_position <= ~meas_position;
      if (meas_start) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
        pos_q <= pos_in;
        val_q <= valid_in;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        meas_done <= 1'b1;
        meas_valid <= val_q;
        meas_position <= pos_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : pms_frontend_model

// ### verif/tb.sv
// self-checking bench for the position measure sequencer
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_n, continuous_run, go, pipeline_request, incremental_request;
  logic sync_trigger_input_n, res_ready, fe_valid;
  logic [3:0] abs_sel, filt_sel;
  logic [15:0] interval;
  logic [7:0] fe_lat;
  logic meas_start, meas_coarse, meas_done, meas_valid, pipeline_active_flag;
  logic res_valid, res_incremental_flag, res_position_valid;
  logic [pms_pkg::POS_W-1:0] meas_position, res_position, fe_pos;
  int fails, comparisons, starts;
  logic q_flag[$]; // popped incremental flags
  logic q_val[$]; // popped validity bits
  logic [pms_pkg::POS_W-1:0] q_pos[$]; // popped positions
  logic q_coarse[$]; // coarse level at each start

  pms_sequencer u_pms_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .continuous_run(continuous_run), .go(go), .pipeline_request(pipeline_request),
    .incremental_request(incremental_request), .absolute_interval_select(abs_sel),
    .filter_coefficient_select(filt_sel), .sample_interval_setting(interval),
    .sync_trigger_input_n(sync_trigger_input_n), .meas_start(meas_start),
    .meas_coarse(meas_coarse), .meas_done(meas_done), .meas_valid(meas_valid),
    .meas_position(meas_position), .pipeline_active_flag(pipeline_active_flag),
    .res_valid(res_valid), .res_ready(res_ready), .res_position(res_position),
    .res_incremental_flag(res_incremental_flag), .res_position_valid(res_position_valid));
  pms_frontend_model u_pms_frontend_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .meas_start(meas_start), .lat(fe_lat), .pos_in(fe_pos), .valid_in(fe_valid),
    .meas_done(meas_done), .meas_valid(meas_valid), .meas_position(meas_position));

  ////////////////////////////////////////////////////////////////
  // clock and collectors
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (res_valid && res_ready) begin
      q_flag.push_back(res_incremental_flag);
      q_val.push_back(res_position_valid);
      q_pos.push_back(res_position);
    end
    if (meas_start) begin
      q_coarse.push_back(meas_coarse);
      starts++;
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_pos(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pos
  task automatic clear_q;
    q_flag.delete();
    q_val.delete();
    q_pos.delete();
    q_coarse.delete();
    starts = 0;
  endtask : clear_q
  // host stops all modes before setting changes other than the live filt_sel changes
  task automatic stop_run;
    @(negedge sys_clk);
    {continuous_run, go, pipeline_request} = 3'h0;
    repeat (30) @(negedge sys_clk);
    clear_q();
  endtask : stop_run
  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && q_flag.size() < n; i++) @(negedge sys_clk);
    chk_bit("words arrived", 1'b1, q_flag.size() >= n);
  endtask : wait_words
  // one sync-pin trigger of one link period with the values for that sample
  task automatic sync_sample(input logic req, input logic [23:0] pos, input logic val);
    incremental_request = req;
    fe_pos = pos;
    fe_valid = val;
    sync_trigger_input_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    sync_trigger_input_n = 1'b1;
    repeat (40) @(negedge sys_clk);
  endtask : sync_sample
  task automatic start_pipe;
    abs_sel = 4'hC;
    incremental_request = 1'b1;
    {continuous_run, go, pipeline_request} = 3'h3;
    repeat (4) @(negedge sys_clk);
  endtask : start_pipe

  ////////////////////////////////////////////////////////////////
  // scenarios
  // timed runs with automatic absolute scheduling for several run lengths
  task automatic t_auto_run;
    for (int s = 0; s < 3; s++) begin
      stop_run();
      abs_sel = 4'(s);
      incremental_request = 1'b0;
      interval = 16'h0003;
      {continuous_run, go, pipeline_request} = 3'h7;
      wait_words(7);
      chk_bit("pipeline active", 1'b1, pipeline_active_flag);
      for (int i = 0; i < 7; i++) begin
        chk_bit("incremental flag", (i % ((1 << s) + 1)) != 0, q_flag[i]);
        chk_bit("coarse level", ~q_flag[i], q_coarse[i]);
      end
      stop_run();
      repeat (100) @(negedge sys_clk);
      chk_bit("no start after stop", 1'b1, starts == 0);
    end
  endtask : t_auto_run
  // host clears the request for one sample and restores it
  task automatic t_host_request;
    logic [4:0] req;
    logic [4:0] flag;
    req = 5'h1B;
    flag = 5'h0D;
    stop_run();
    filt_sel = 4'h0;
    start_pipe();
    for (int i = 0; i < 5; i++) sync_sample(req[4-i], 24'h000040 + 24'(i * 256), 1'b1);
    wait_words(5);
    for (int i = 0; i < 5; i++) begin
      chk_bit("host request flag", flag[4-i], q_flag[i]);
      chk_pos("raw position", 24'h000040 + 24'(i * 256), q_pos[i]);
    end
    chk_bit("coarse after restore", 1'b1, q_coarse[3]);
  endtask : t_host_request
  // filter with load, invalid sample and a live coefficient change
  task automatic t_filter;
    logic [23:0] raw[6];
    logic [23:0] exp[6];
    logic [5:0] val;
    logic [5:0] flag;
    raw = '{24'h001000, 24'h003000, 24'h007777, 24'h005000, 24'h005100, 24'h005480};
    exp = '{24'h001000, 24'h002000, 24'h007777, 24'h005000, 24'h005080, 24'h005180};
    val = 6'h37;
    flag = 6'h1B;
    stop_run();
    filt_sel = 4'h2;
    start_pipe();
    for (int i = 0; i < 6; i++) begin
      if (i == 5) filt_sel = 4'h4;
      sync_sample(1'b1, raw[i], val[5-i]);
    end
    wait_words(6);
    for (int i = 0; i < 6; i++) begin
      chk_pos("filtered position", exp[i], q_pos[i]);
      chk_bit("position valid", val[5-i], q_val[i]);
      chk_bit("fallback flag", flag[5-i], q_flag[i]);
    end
    filt_sel = 4'h0;
  endtask : t_filter
  // consumer stalls: the buffer fills, blocks triggers, then drains
  task automatic t_stall;
    stop_run();
    fe_lat = 8'h0C;
    res_ready = 1'b0;
    abs_sel = 4'h0;
    incremental_request = 1'b0;
    {continuous_run, go, pipeline_request} = 3'h7;
    repeat (400) @(negedge sys_clk);
    chk_bit("starts while full", 1'b1, starts == pms_pkg::FIFO_DEPTH);
    chk_bit("word waiting", 1'b1, res_valid);
    {continuous_run, go, pipeline_request} = 3'h0;
    repeat (30) @(negedge sys_clk);
    res_ready = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk_bit("drained count", 1'b1, q_flag.size() == pms_pkg::FIFO_DEPTH);
    chk_bit("empty after drain", 1'b0, res_valid);
    fe_lat = 8'h02;
  endtask : t_stall

  ////////////////////////////////////////////////////////////////
  // verdict
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {continuous_run, go, pipeline_request} = 3'h0;
    incremental_request = 1'b1;
    sync_trigger_input_n = 1'b1;
    res_ready = 1'b1;
    abs_sel = 4'hC;
    filt_sel = 4'h0;
    interval = 16'h0003;
    fe_lat = 8'h02;
    fe_pos = 24'h000000;
    fe_valid = 1'b1;
    fails = 0;
    comparisons = 0;
    starts = 0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_auto_run();
    t_host_request();
    t_filter();
    t_stall();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule : tb
